// *** src/three_phase_inverter_pwm.sv ***
// Overview of operation
// - Six gate outputs: high and low side for legs a, b, c.
// - 16-bit timer makes three complementary, dead-timed, centred pairs.
// - Period register is ticks per half period, full period twice.
// - One tick is one cycle of the block clock.
// - Gap between one side off and other on is dead*2 ticks.
// - Dead-time setting is 10 bits, up to 0x3FF, step two ticks.
// - Dead time zero makes complementary edges coincide.
// - Programmable minimum pulse width applies to generated pulses.
// - Three 16-bit duty registers set each leg's on-time.
// - Each output has an enable bit; disabled output stays off.
// - Crossover bit per leg swaps high and low waveforms.
// - 8-bit gate value sets the chopping frequency.
// - Chopping enabled separately for high sides and low sides.
// - Single update mode takes new duties once per period.
// - Double update mode also takes new values at midpoint.
// - Mode bit 6 selects single (clear) or double (set) update.
// - Sync pulse every period start, plus midpoint in double mode.
// - Sync pulse width comes from the sync-width register.
// - Low trip pin forces all outputs off without any clock.
// - Overcurrent indication forces all outputs off asynchronously.
// - Software shutdown write stops outputs; every shutdown resets timer.
// - Status shows trip pin level and current half-period flag.
// - Interrupt on each sync pulse and on any shutdown.
// - Sync rising edge latches timing, duty and segment registers.
// - Sync pulse lasts width+1 ticks; width resets to 0x27.
// - Status bit 3 clear in first half, set in second half.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module three_phase_inverter_pwm #(
	parameter int CNT_W = 16,
	parameter int DT_W  = 10
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire pwm_pkg::axi_req_t axi_req,
	output pwm_pkg::axi_rsp_t      axi_rsp,
	input  wire logic              trip_pin_n,
	input  wire logic              current_sense_trip,
	output logic                   phase_a_high_out,
	output logic                   phase_a_low_out,
	output logic                   phase_b_high_out,
	output logic                   phase_b_low_out,
	output logic                   phase_c_high_out,
	output logic                   phase_c_low_out,
	output logic                   sync_pulse,
	output logic                   sync_irq,
	output logic                   shutdown_irq
);
	import pwm_pkg::*;

	localparam int W = CNT_W + 2;

	// The comparators and register slots cannot serve other sizes
	if (CNT_W < 2 || CNT_W > 32 || DT_W < 1 || DT_W > CNT_W) begin : g_bad
		$error("three_phase_inverter_pwm: unsupported CNT_W or DT_W");
	end

	typedef struct packed {
		pwm_state_t                st;
		logic [1:0]                trip_sync;
		logic [1:0]                oc_sync;
		logic [CNT_W-1:0]          period;
		logic [CNT_W-1:0]          minw;
		logic [2:0][CNT_W-1:0]     duty;
		logic [DT_W-1:0]           dead;
		logic [8:0]                seg;
		logic [9:0]                gate;
		logic                      mode_dbl;
		logic [7:0]                syncw;
		logic [CNT_W-1:0]          a_period;
		logic [CNT_W-1:0]          a_minw;
		logic [2:0][CNT_W-1:0]     a_duty;
		logic [DT_W-1:0]           a_dead;
		logic [8:0]                a_seg;
		logic [7:0]                a_syncw;
		logic [CNT_W-1:0]          cnt;
		logic                      half;
		logic [7:0]                sync_cnt;
		logic                      sync_on;
		logic [7:0]                chop_cnt;
		logic                      chop;
		logic [5:0]                outs;
		logic                      sync_irq;
		logic                      shut_irq;
		logic                      aw_got;
		logic                      w_got;
		logic [ADDR_W-1:0]         awaddr;
		logic [31:0]               wdata;
		logic [3:0]                wstrb;
		axi_rsp_t                  rsp;
	} state_t;

	state_t           s;
	state_t           next_s;
	logic             hw_trip;
	logic             wr_fire;
	logic             sw_shut;
	logic             restart;
	logic             wrap;
	logic             sync_start;
	logic [32:0]      rd_hit;
	logic [32:0]      old_hit;
	logic [31:0]      wv;
	logic [W-1:0]     c;
	logic [W-1:0]     d;
	logic [W-1:0]     t;
	logic [W-1:0]     k;
	logic [W-1:0]     m;
	logic             hi;
	logic             lo;
	logic             oh;
	logic             ol;
	logic [5:0]       wave;
	logic             pins_ok;

	// Register view {hit, data}; unmapped addresses miss
	function automatic logic [32:0] reg_val(input state_t st,
		input logic [ADDR_W-1:0] a);
		logic [32:0] r;
		r = '0;
		case (a)
			OFS_PERIOD:  r = {1'b1, 32'(st.period)};
			OFS_DEAD:    r = {1'b1, 32'(st.dead)};
			OFS_MINW:    r = {1'b1, 32'(st.minw)};
			OFS_DUTY_A:  r = {1'b1, 32'(st.duty[0])};
			OFS_DUTY_B:  r = {1'b1, 32'(st.duty[1])};
			OFS_DUTY_C:  r = {1'b1, 32'(st.duty[2])};
			OFS_SEG:     r = {1'b1, 32'(st.seg)};
			OFS_GATE:    r = {1'b1, 32'(st.gate)};
			OFS_MODE:    r = {1'b1, 32'(st.mode_dbl) << MODE_DBL_BIT};
			OFS_SYNCW:   r = {1'b1, 32'(st.syncw)};
			OFS_SWSHUT:  r = {1'b1, 32'h0000_0000};
			OFS_RESTART: r = {1'b1, 32'h0000_0000};
			OFS_STATUS: begin
				r[32] = 1'b1;
				r[STAT_TRIP_BIT] = st.trip_sync[1];
				r[STAT_SHUT_BIT] = (st.st == ST_SHUT);
				r[STAT_HALF_BIT] = st.half;
			end
			default:     r = '0;
		endcase
		return r;
	endfunction

	// Byte-lane merge so partial writes keep the other lanes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Next-state logic for bus, timer, waveforms and shutdown
	always_comb begin
		next_s = s;
		next_s.trip_sync = {s.trip_sync[0], trip_pin_n};
		next_s.oc_sync   = {s.oc_sync[0], current_sense_trip};
		next_s.sync_irq  = 1'b0;
		next_s.shut_irq  = 1'b0;
		hw_trip = !s.trip_sync[1] || s.oc_sync[1];
		wr_fire = s.aw_got && s.w_got;
		old_hit = reg_val(s, s.awaddr);
		wv      = merge(old_hit[31:0], s.wdata, s.wstrb);
		rd_hit  = reg_val(s, axi_req.araddr);
		sw_shut = wr_fire && (s.awaddr == OFS_SWSHUT);
		restart = wr_fire && (s.awaddr == OFS_RESTART) && wv[RESTART_BIT];

		// Address and data are taken in either order, then answered
		if (axi_req.awvalid && s.rsp.awready) begin
			next_s.aw_got      = 1'b1;
			next_s.awaddr      = axi_req.awaddr;
			next_s.rsp.awready = 1'b0;
		end
		if (axi_req.wvalid && s.rsp.wready) begin
			next_s.w_got      = 1'b1;
			next_s.wdata      = axi_req.wdata;
			next_s.wstrb      = axi_req.wstrb;
			next_s.rsp.wready = 1'b0;
		end
		if (wr_fire) begin
			next_s.aw_got     = 1'b0;
			next_s.w_got      = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp  = old_hit[32] ? RESP_OKAY : RESP_SLVERR;
			case (s.awaddr)
				OFS_PERIOD: next_s.period  = wv[CNT_W-1:0];
				OFS_DEAD:   next_s.dead    = wv[DT_W-1:0];
				OFS_MINW:   next_s.minw    = wv[CNT_W-1:0];
				OFS_DUTY_A: next_s.duty[0] = wv[CNT_W-1:0];
				OFS_DUTY_B: next_s.duty[1] = wv[CNT_W-1:0];
				OFS_DUTY_C: next_s.duty[2] = wv[CNT_W-1:0];
				OFS_SEG:    next_s.seg     = wv[8:0];
				OFS_GATE:   next_s.gate    = wv[9:0];
				OFS_MODE:   next_s.mode_dbl = wv[MODE_DBL_BIT];
				OFS_SYNCW:  next_s.syncw   = wv[7:0];
				default:    next_s.syncw   = s.syncw;
			endcase
		end
		if (s.rsp.bvalid && axi_req.bready) begin
			next_s.rsp.bvalid  = 1'b0;
			next_s.rsp.awready = 1'b1;
			next_s.rsp.wready  = 1'b1;
		end

		// Reads answer one cycle after the address is taken
		if (axi_req.arvalid && s.rsp.arready) begin
			next_s.rsp.arready = 1'b0;
			next_s.rsp.rvalid  = 1'b1;
			next_s.rsp.rdata   = rd_hit[31:0];
			next_s.rsp.rresp   = rd_hit[32] ? RESP_OKAY : RESP_SLVERR;
		end
		if (s.rsp.rvalid && axi_req.rready) begin
			next_s.rsp.rvalid  = 1'b0;
			next_s.rsp.arready = 1'b1;
		end

		// Half-period counter; each tick is one clock
		wrap = ({1'b0, s.cnt} + 1'b1) >= {1'b0, s.a_period};
		sync_start = 1'b0;
		unique case (s.st)
			ST_SHUT: begin
				next_s.cnt  = '0;
				next_s.half = 1'b0;
				if (restart && !hw_trip) begin
					next_s.st = ST_START;
				end
			end
			ST_START: begin
				sync_start  = 1'b1;                            // Count already clear
				next_s.st   = ST_RUN;
			end
			ST_RUN: begin
				if (wrap) begin
					next_s.cnt  = '0;
					next_s.half = !s.half;
					// Midpoint reload only in double update mode
					sync_start = s.half || s.mode_dbl;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
		endcase

		// Any shutdown source resets the timer and holds it stopped
		if ((hw_trip || sw_shut) && s.st != ST_SHUT) begin
			next_s.st       = ST_SHUT;
			next_s.shut_irq = 1'b1;
			next_s.cnt      = '0;
			next_s.half     = 1'b0;
			sync_start      = 1'b0;
		end

		// Sync pulse opens by latching the working copies
		if (sync_start) begin
			next_s.a_period = s.period;
			next_s.a_minw   = s.minw;
			next_s.a_duty   = s.duty;
			next_s.a_dead   = s.dead;
			next_s.a_seg    = s.seg;
			next_s.a_syncw  = s.syncw;
			next_s.sync_on  = 1'b1;
			next_s.sync_cnt = s.syncw;
			next_s.sync_irq = 1'b1;
		end else if (s.sync_on) begin
			if (s.sync_cnt == '0) begin
				next_s.sync_on = 1'b0;
			end else begin
				next_s.sync_cnt = s.sync_cnt - 1'b1;
			end
		end

		// Chopper toggles every gate value + 1 ticks
		if (s.chop_cnt >= s.gate[7:0]) begin
			next_s.chop_cnt = '0;
			next_s.chop     = !s.chop;
		end else begin
			next_s.chop_cnt = s.chop_cnt + 1'b1;
		end

		// Centred edges, each moved inward by the dead time
		c = W'(s.cnt);
		t = W'(s.a_period);
		k = W'(s.a_dead);
		m = W'(s.a_minw);
		wave = '0;
		for (int i = 0; i < 3; i++) begin
			d = W'(s.a_duty[i]);
			hi = s.half ? (c + k < d) : (c + d >= t + k);
			lo = s.half ? (c >= d + k) : (c + d + k < t);
			// Pulses narrower than twice the minimum are dropped
			hi = hi && (d >= k + m);
			lo = lo && (t >= d + k + m);
			oh = s.a_seg[SEG_XOVER_LSB + i] ? lo : hi;
			ol = s.a_seg[SEG_XOVER_LSB + i] ? hi : lo;
			oh = oh && (!s.gate[GATE_HI_BIT] || s.chop);
			ol = ol && (!s.gate[GATE_LO_BIT] || s.chop);
			wave[2*i]     = oh && s.a_seg[2*i];
			wave[2*i + 1] = ol && s.a_seg[2*i + 1];
		end
		next_s.outs = (next_s.st == ST_RUN && s.st == ST_RUN) ? wave : '0;
	end

	// Single state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s             <= '0;
			s.st          <= ST_START;
			s.trip_sync   <= 2'b11;
			s.period      <= CNT_W'(RST_PERIOD);
			s.duty        <= {3{CNT_W'(RST_DUTY)}};
			s.seg         <= RST_SEG;
			s.gate        <= RST_GATE;
			s.syncw       <= RST_SYNCW;
			s.rsp.awready <= 1'b1;
			s.rsp.wready  <= 1'b1;
			s.rsp.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// Trip gating is unclocked so it works with the clock stopped
	assign pins_ok = trip_pin_n & !current_sense_trip;
	assign phase_a_high_out = s.outs[0] & pins_ok;
	assign phase_a_low_out  = s.outs[1] & pins_ok;
	assign phase_b_high_out = s.outs[2] & pins_ok;
	assign phase_b_low_out  = s.outs[3] & pins_ok;
	assign phase_c_high_out = s.outs[4] & pins_ok;
	assign phase_c_low_out  = s.outs[5] & pins_ok;
	assign axi_rsp      = s.rsp;
	assign sync_pulse   = s.sync_on;
	assign sync_irq     = s.sync_irq;
	assign shutdown_irq = s.shut_irq;

	// Length of the running sync pulse, read only by checks; a new pulse
	// that starts before the old one ends restarts the count
	logic [8:0] sync_len;
	always_ff @(posedge aclk) begin
		sync_len <= (aresetn && s.sync_on && !sync_start) ? sync_len + 1'b1
			: 9'h000;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_sw_shut;
		wr_fire && s.awaddr == OFS_SWSHUT && s.st != ST_SHUT;
	endsequence
	sequence seq_shut_held;
		s.st == ST_SHUT && s.outs == '0;
	endsequence

	chk_trip_forces_off: assert property (
		!trip_pin_n |-> {phase_a_high_out, phase_a_low_out,
			phase_b_high_out, phase_b_low_out,
			phase_c_high_out, phase_c_low_out} == 6'h00)
		else $error("outputs active while trip pin low");
	chk_oc_forces_off: assert property (
		current_sense_trip |-> !(phase_a_high_out || phase_b_high_out ||
			phase_c_high_out || phase_a_low_out || phase_b_low_out ||
			phase_c_low_out))
		else $error("outputs active during overcurrent");
	chk_sw_shutdown: assert property (
		seq_sw_shut |=> seq_shut_held ##0 shutdown_irq ##1 s.cnt == '0)
		else $error("software shutdown not taken");
	chk_shut_held: assert property (
		s.st == ST_SHUT && !restart |=> seq_shut_held)
		else $error("left shutdown without restart");
	chk_dead_gap: assert property (
		s.a_dead != '0 && s.a_seg[SEG_XOVER_LSB] == 1'b0
		|-> !(s.outs[0] && s.outs[1]))
		else $error("both sides of leg a on with dead time set");
	chk_sync_width: assert property (
		$fell(s.sync_on) && !$past(sync_start, 2)
		|-> sync_len == 9'($past(s.a_syncw)) + 9'h001)
		else $error("sync pulse width wrong");
	chk_sync_latch: assert property (
		$rose(s.sync_on) |-> s.a_period == $past(s.period)
			&& s.a_duty == $past(s.duty) && s.a_seg == $past(s.seg))
		else $error("registers not latched at sync");
	chk_single_mode: assert property (
		$rose(s.sync_on) && !$past(s.mode_dbl) |-> !s.half)
		else $error("midpoint sync in single update mode");
	chk_half_flag: assert property (
		s.st == ST_RUN && wrap && !s.half && !hw_trip && !sw_shut
		|=> s.half ##0 (s.sync_on == $past(s.mode_dbl) || $past(s.sync_on)))
		else $error("half flag or midpoint sync wrong");
	chk_sync_irq: assert property (
		$rose(s.sync_on) |-> sync_irq)
		else $error("no interrupt with sync pulse");
	chk_enable_off: assert property (
		!$past(s.a_seg[2]) |-> !s.outs[2])
		else $error("disabled output driven");

endmodule // three_phase_inverter_pwm

// *** src/pwm_pkg.sv ***
package pwm_pkg;

	// Register byte addresses on the AXI4-Lite port
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_PERIOD   = 8'h00;
	localparam logic [7:0]  OFS_DEAD     = 8'h04;
	localparam logic [7:0]  OFS_MINW     = 8'h08;
	localparam logic [7:0]  OFS_DUTY_A   = 8'h0C;
	localparam logic [7:0]  OFS_DUTY_B   = 8'h10;
	localparam logic [7:0]  OFS_DUTY_C   = 8'h14;
	localparam logic [7:0]  OFS_SEG      = 8'h18;
	localparam logic [7:0]  OFS_GATE     = 8'h1C;
	localparam logic [7:0]  OFS_MODE     = 8'h20;
	localparam logic [7:0]  OFS_SYNCW    = 8'h24;
	localparam logic [7:0]  OFS_SWSHUT   = 8'h28;
	localparam logic [7:0]  OFS_STATUS   = 8'h2C;
	localparam logic [7:0]  OFS_RESTART  = 8'h30;

	// Field positions
	localparam int          MODE_DBL_BIT  = 6;
	localparam int          STAT_TRIP_BIT = 0;
	localparam int          STAT_SHUT_BIT = 1;
	localparam int          STAT_HALF_BIT = 3;
	localparam int          SEG_XOVER_LSB = 6;
	localparam int          GATE_HI_BIT   = 8;
	localparam int          GATE_LO_BIT   = 9;
	localparam int          RESTART_BIT   = 0;

	// Reset values
	localparam logic [15:0] RST_PERIOD   = 16'h0000;
	localparam logic [15:0] RST_DUTY     = 16'h0000;
	localparam logic [8:0]  RST_SEG      = 9'h03F;
	localparam logic [9:0]  RST_GATE     = 10'h000;
	localparam logic [7:0]  RST_SYNCW    = 8'h27;

	// Bus answers
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// Controller states, Gray along shut -> start -> run
	typedef enum logic [1:0] {
		ST_SHUT  = 2'b00,
		ST_START = 2'b01,
		ST_RUN   = 2'b11
	} pwm_state_t;

	// Master-driven AXI4-Lite signals
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              awvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              wvalid;
		logic              bready;
		logic [ADDR_W-1:0] araddr;
		logic              arvalid;
		logic              rready;
	} axi_req_t;

	// Slave-driven AXI4-Lite signals
	typedef struct packed {
		logic              awready;
		logic              wready;
		logic [1:0]        bresp;
		logic              bvalid;
		logic              arready;
		logic [31:0]       rdata;
		logic [1:0]        rresp;
		logic              rvalid;
	} axi_rsp_t;

endpackage

// *** testbench/gate_driver_model.sv ***
`timescale 1ns/100ps
// Stand-in for the inverter gate drivers: remembers any cycle in which
// both switches of one leg are commanded on, which would short the link.
module gate_driver_model (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic [5:0] gates,
	output logic            fault
);
	// Sticky, so a single overlapping cycle is never lost
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault <= 1'b0;
		end else if ((gates[0] & gates[1]) | (gates[2] & gates[3])
				| (gates[4] & gates[5])) begin
			fault <= 1'b1;
		end
	end
endmodule // gate_driver_model

// *** testbench/three_phase_inverter_pwm_tb.sv ***
`timescale 1ns/100ps
module three_phase_inverter_pwm_tb;
	import pwm_pkg::*;
	localparam int P = 20;
	localparam int D = 12;
	localparam int K = 3;
	logic        aclk;
	logic        aresetn;
	axi_req_t    axi_req;
	axi_rsp_t    axi_rsp;
	logic        trip_pin_n;
	logic        current_sense_trip;
	logic        ah, al, bh, bl, ch, cl, syn, sirq, dirq;
	logic [8:0]  mon;
	logic        fault;
	logic [31:0] rv;
	logic [1:0]  rs;
	logic        s1;
	int          n;
	int          n_mismatch;
	int          checks;

	// Index 0 a high, 1 a low, 6 sync, 7 sync irq, 8 shutdown irq
	assign mon = {dirq, sirq, syn, cl, ch, bl, bh, al, ah};

	three_phase_inverter_pwm three_phase_inverter_pwm_inst (
		.aclk(aclk), .aresetn(aresetn), .axi_req(axi_req),
		.axi_rsp(axi_rsp), .trip_pin_n(trip_pin_n),
		.current_sense_trip(current_sense_trip),
		.phase_a_high_out(ah), .phase_a_low_out(al),
		.phase_b_high_out(bh), .phase_b_low_out(bl),
		.phase_c_high_out(ch), .phase_c_low_out(cl),
		.sync_pulse(syn), .sync_irq(sirq), .shutdown_irq(dirq));

	gate_driver_model gate_driver_model_inst (
		.aclk(aclk), .aresetn(aresetn), .gates(mon[5:0]), .fault(fault));

	// 10 MHz clock
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit b;
		b = 0;
		@(posedge aclk);
		axi_req.awaddr <= a;
		axi_req.awvalid <= 1'b1;
		axi_req.wdata <= d;
		axi_req.wstrb <= 4'hF;
		axi_req.wvalid <= 1'b1;
		axi_req.bready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			if (axi_req.awvalid && axi_rsp.awready) axi_req.awvalid <= 1'b0;
			if (axi_req.wvalid && axi_rsp.wready) axi_req.wvalid <= 1'b0;
			if (axi_rsp.bvalid) begin
				rs = axi_rsp.bresp;
				b = 1;
			end
		end
		axi_req.bready <= 1'b0;
	endtask

	task rd(input logic [7:0] a);
		bit r;
		r = 0;
		@(posedge aclk);
		axi_req.araddr <= a;
		axi_req.arvalid <= 1'b1;
		axi_req.rready <= 1'b1;
		while (!r) begin
			@(posedge aclk);
			if (axi_req.arvalid && axi_rsp.arready) axi_req.arvalid <= 1'b0;
			if (axi_rsp.rvalid) begin
				rv = axi_rsp.rdata;
				rs = axi_rsp.rresp;
				r = 1;
			end
		end
		axi_req.rready <= 1'b0;
	endtask

	// Edges until a monitored line reaches a level
	task til(input int i, input logic v);
		n = 0;
		while (mon[i] !== v) begin
			@(posedge aclk);
			n++;
		end
	endtask

	task hcount(input int i, input int span);
		n = 0;
		repeat (span) begin
			@(posedge aclk);
			if (mon[i] === 1'b1) n++;
		end
	endtask

	task sync_rise;
		til(6, 1'b0);
		til(6, 1'b1);
	endtask

	task t_regs;
		rd(OFS_SYNCW); chk(rv, 32'h27);
		rd(OFS_SEG); chk(rv, 32'h3F);
		rd(OFS_MODE); chk(rv[MODE_DBL_BIT], 0);
		wr(OFS_DEAD, 32'hFFFF); rd(OFS_DEAD); chk(rv, 32'h3FF);
		wr(OFS_DUTY_B, 32'h1FFFF); rd(OFS_DUTY_B); chk(rv, 32'hFFFF);
		wr(8'h40, 32'h1); chk(rs, RESP_SLVERR);
		rd(8'h40); chk(rs, RESP_SLVERR);
	endtask

	// Values only land at a period start, so wait two syncs
	task t_setup;
		wr(OFS_PERIOD, P);
		wr(OFS_DUTY_A, D);
		wr(OFS_DUTY_B, D);
		wr(OFS_SYNCW, 32'h4);
		sync_rise;
		sync_rise;
	endtask

	task t_sync;
		sync_rise;
		til(6, 1'b0); chk(n, 5);
		til(6, 1'b1); chk(n + 5, 2 * P);
		hcount(7, 2 * P); chk(n, 1);
	endtask

	task t_dead(input int k);
		wr(OFS_DEAD, k);
		sync_rise;
		sync_rise;
		til(1, 1'b1);
		til(1, 1'b0);
		til(0, 1'b1); chk(n, 2 * k);
		hcount(0, 2 * P); chk(n, 2 * (D - k));
		hcount(1, 2 * P); chk(n, 2 * (P - D - k));
		hcount(2, 2 * P); chk(n, 2 * (D - k));
	endtask

	task t_seg;
		wr(OFS_SEG, 32'h7F);
		sync_rise;
		sync_rise;
		hcount(0, 2 * P); chk(n, 2 * (P - D - K));
		wr(OFS_SEG, 32'h3E);
		sync_rise;
		sync_rise;
		hcount(0, 2 * P); chk(n, 0);
		hcount(1, 2 * P); chk(n, 2 * (P - D - K));
		wr(OFS_SEG, 32'h3F);
	endtask

	// Low pulse halves of P-D-K ticks are below a minimum of 6, so the pulse is dropped;
	// the syncs here also land the enables restored at the end of t_seg
	task t_minw;
		wr(OFS_MINW, 32'h6);
		sync_rise;
		sync_rise;
		hcount(0, 2 * P); chk(n, 2 * (D - K));
		hcount(1, 2 * P); chk(n, 0);
		wr(OFS_MINW, 32'h0);
		sync_rise;
		sync_rise;
	endtask

	// Chop value 0 toggles every cycle: half the chopped on-time remains
	task t_chop;
		wr(OFS_GATE, 32'h100);
		hcount(0, 2 * P); chk(n, D - K);
		hcount(1, 2 * P); chk(n, 2 * (P - D - K));
		wr(OFS_GATE, 32'h200);
		hcount(0, 2 * P); chk(n, 2 * (D - K));
		hcount(1, 2 * P); chk(n, P - D - K);
		wr(OFS_GATE, 32'h0);
	endtask

	task t_double;
		wr(OFS_MODE, 32'h40);
		sync_rise;
		til(6, 1'b0);
		til(6, 1'b1); chk(n + 5, P);
		repeat (3) @(posedge aclk);
		rd(OFS_STATUS);
		s1 = rv[STAT_HALF_BIT];
		sync_rise;
		repeat (3) @(posedge aclk);
		rd(OFS_STATUS); chk(rv[STAT_HALF_BIT] ^ s1, 1);
		wr(OFS_MODE, 32'h0);
	endtask

	// Source 0 trip pin, 1 overcurrent, 2 software
	task shut(input int src);
		til(0, 1'b1);
		if (src == 2) begin
			wr(OFS_SWSHUT, 32'h1);
			#1 chk(mon[5:0], 0);
		end else begin
			@(posedge aclk);
			trip_pin_n <= (src != 0);
			current_sense_trip <= (src == 1);
			#1 chk(mon[5:0], 0);
			hcount(8, 8); chk(n, 1);
		end
		rd(OFS_STATUS); chk(rv[1:0], {1'b1, src != 0});
		trip_pin_n <= 1'b1;
		current_sense_trip <= 1'b0;
		hcount(0, 2 * P); chk(n, 0);
		wr(OFS_RESTART, 32'h1);
		sync_rise;
		sync_rise;
		hcount(0, 2 * P); chk(n, 2 * (D - K));
	endtask

	task results;
		$display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence; dead time zero first so K stays set afterwards
	initial begin
		aresetn = 1'b0;
		axi_req = '0;
		trip_pin_n = 1'b1;
		current_sense_trip = 1'b0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_setup;
		t_sync;
		t_dead(0);
		t_dead(K);
		t_seg;
		t_minw;
		t_chop;
		t_double;
		shut(0);
		shut(1);
		shut(2);
		chk(fault, 0);
		results;
	end

	// Whole run needs a few thousand cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		$display("MISMATCH at %0t: timeout", $time);
		results;
	end
endmodule // three_phase_inverter_pwm_tb
